// *** src/ptc_pkg.sv ***
// shared register map, field positions and reset values for the pll test and clock gating block
package ptc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [15:0] PTC_OFF_TEST = 16'h606C;
  localparam logic [15:0] PTC_OFF_PSTATE = 16'h6104;
  localparam logic [15:0] PTC_OFF_STATUS = 16'h6108;
  localparam logic [15:0] PTC_OFF_DISP = 16'h6200;
  localparam logic [15:0] PTC_OFF_REND = 16'h6204;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [31:0] PTC_RST_TEST = 32'h00010001;
  localparam logic [31:0] PTC_RST_PSTATE = 32'h00000000;
  localparam logic [31:0] PTC_RST_DISP = 32'h01000000;
  localparam logic [31:0] PTC_RST_REND = 32'h00000000;
  localparam logic [31:0] PTC_MASK_TEST = 32'h000F003F;
  localparam logic [31:0] PTC_MASK_PSTATE = 32'h0000000B;
  localparam logic [31:0] PTC_MASK_DISP = 32'h7FFFFFFF;
  localparam logic [31:0] PTC_MASK_DISP_NC = 32'h94F07000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PTC_B_NDIV_B = 19;
  localparam int PTC_B_MDIV_B = 18;
  localparam int PTC_B_FBSEL_B = 17;
  localparam int PTC_B_BUF_B = 16;
  localparam int PTC_B_POSTDIV = 4;
  localparam int PTC_B_NDIV_A = 3;
  localparam int PTC_B_MDIV_A = 2;
  localparam int PTC_B_FBSEL_A = 1;
  localparam int PTC_B_BUF_A = 0;
  localparam int PTC_B_PD_D3 = 3;
  localparam int PTC_B_CORE_D3 = 1;
  localparam int PTC_B_DOT_D3 = 0;
  localparam int PTC_B_PLANE_B = 30;
  localparam int PTC_B_PLANE_A = 25;
  localparam int PTC_B_GAMMA_B = 8;
  localparam int PTC_B_GAMMA_A = 7;
  localparam int PTC_DISP_UNITS = 31;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0] PTC_PM_D3 = 2'h3;
  localparam logic [1:0] PTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTC_RESP_SLVERR = 2'h2;

  // merge a strobed write into a register, keeping read-only bits at zero
  function automatic logic [31:0] ptc_merge(input logic [31:0] old, input logic [31:0] wdata,
                                           input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~lanes) | (wdata & lanes)) & mask;
  endfunction

endpackage

// *** src/ptc_clk_gate.sv ***
// glitch-free clock gate: enable re-timed into the gated clock, held while clock is high
`timescale 1ns/1ns
module ptc_clk_gate
(
  input wire logic clk_in,
  input wire logic gate_en,
  output logic clk_out
);

  logic sync_a;
  logic sync_b;
  logic en_low;

  // two-stage crossing from the register clock into the gated clock
  always_ff @(posedge clk_in)
  begin
    sync_a <= gate_en;
    sync_b <= sync_a;
  end

  // enable only moves while the clock is low, so no pulse is ever cut short
  always_ff @(negedge clk_in)
  begin
    en_low <= sync_b;
  end

  assign clk_out = clk_in & en_low;

endmodule

// *** src/ptc_axil_slave.sv ***
// axi4-lite slave front end: holds address and data, issues one access, returns the answer
`timescale 1ns/1ns
module ptc_axil_slave
  import ptc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [15:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [15:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_full;
  logic w_full;
  logic ar_full;

  assign wr_en = aw_full & w_full & ~s_axil_bvalid;

  // write address and data are taken independently, in either order
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (s_axil_awvalid && s_axil_awready)
      begin
        aw_full <= 1'b1;
        wr_addr <= s_axil_awaddr;
        s_axil_awready <= 1'b0;
      end
      else if (wr_en)
        aw_full <= 1'b0;
      else if (!aw_full && !s_axil_bvalid)
        s_axil_awready <= 1'b1;
      if (s_axil_wvalid && s_axil_wready)
      begin
        w_full <= 1'b1;
        wr_data <= s_axil_wdata;
        wr_strb <= s_axil_wstrb;
        s_axil_wready <= 1'b0;
      end
      else if (wr_en)
        w_full <= 1'b0;
      else if (!w_full && !s_axil_bvalid)
        s_axil_wready <= 1'b1;
    end
  end

  // response follows the access by one edge; unmapped offsets answer slverr
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= PTC_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= wr_hit ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
    end
    else if (s_axil_bready)
      s_axil_bvalid <= 1'b0;
  end

  // read: address held one cycle, then data captured with rvalid
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ar_full <= 1'b0;
      s_axil_arready <= 1'b0;
      rd_addr <= 16'h0000;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= PTC_RESP_OKAY;
    end
    else
    begin
      if (s_axil_arvalid && s_axil_arready)
      begin
        ar_full <= 1'b1;
        rd_addr <= s_axil_araddr;
        s_axil_arready <= 1'b0;
      end
      else if (ar_full)
      begin
        ar_full <= 1'b0;
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_hit ? rd_data : 32'h00000000;
        s_axil_rresp <= rd_hit ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
      end
      else if (s_axil_rvalid && s_axil_rready)
        s_axil_rvalid <= 1'b0;
      else if (!s_axil_rvalid)
        s_axil_arready <= 1'b1;
    end
  end

endmodule

// *** src/ptc_top.sv ***
// pll test pins, d3 power actions and display clock gating disables behind axi4-lite
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns

// ****************************************
// block top
// ****************************************

// Overview of operation
// - input divider bypass bit drives bypass pin
// - feedback divider bypass bit drives bypass pin
// - feedback select bit picks core feedback
// - input buffer bit enables reference buffer
// - post-divider field acts only with core feedback
// - power-down bit powers down dot plls in d3
// - core gating bit gates core clocks in d3
// - dot gating bit gates dot clocks in d3
// - d3 comes from host power state bits
// - disable bit forces unit clock to run
// - variant ignores unconnected display gating bits
// - plane unit disables kept per pipe
// - gamma unit disables kept per pipe
// - test register resets to buffers enabled
module ptc_top
  import ptc_pkg::*;
#(
  parameter bit VARIANT_NC = 1'b0,
  parameter int ADDR_W = 16
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [15:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [1:0] host_power_state,
  input wire logic [30:0] disp_unit_enable,
  input wire logic [1:0] dot_clk_in,
  input wire logic core_clk_in,
  output logic [1:0] input_divider_bypass_pin,
  output logic [1:0] feedback_divider_bypass_pin,
  output logic [1:0] feedback_source_select_pin,
  output logic [1:0] input_buffer_enable_pin,
  output logic [1:0] feedback_postdiv_select_pins,
  output logic dot_pll_power_down,
  output logic [30:0] disp_clk_run,
  output logic [31:0] render_gating_disable,
  output logic [1:0] dot_clk_out,
  output logic core_clk_out
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_W != 16)
  begin : g_bad_addr
    $error("ptc_top: only a 16-bit register address is served");
  end

  // ****************************************
  // bus front end
  // ****************************************
  logic wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_hit;
  logic rd_hit;

  ptc_axil_slave u_bus
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // the five listed register offsets only; anything else is unmapped
  function automatic logic ptc_known(input logic [15:0] a);
    return (a == PTC_OFF_TEST) || (a == PTC_OFF_PSTATE) || (a == PTC_OFF_STATUS) ||
           (a == PTC_OFF_DISP) || (a == PTC_OFF_REND);
  endfunction

  assign wr_hit = ptc_known(wr_addr);
  assign rd_hit = ptc_known(rd_addr);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] pll_test_control;
  logic [31:0] power_state_clock_control;
  logic [31:0] display_gating_disable;
  logic [31:0] render_gating_disable_one;
  logic [31:0] disp_wmask;
  logic [3:0] status_bits;

  // on the trimmed variant the unconnected bits never store
  assign disp_wmask = VARIANT_NC ? (PTC_MASK_DISP & ~PTC_MASK_DISP_NC) : PTC_MASK_DISP;

  // pll test pins register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pll_test_control <= PTC_RST_TEST;
    else if (wr_en && wr_addr == PTC_OFF_TEST)
      pll_test_control <= ptc_merge(pll_test_control, wr_data, wr_strb, PTC_MASK_TEST);
  end

  // d3 action enables
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      power_state_clock_control <= PTC_RST_PSTATE;
    else if (wr_en && wr_addr == PTC_OFF_PSTATE)
      power_state_clock_control <= ptc_merge(power_state_clock_control, wr_data, wr_strb,
                                             PTC_MASK_PSTATE);
  end

  // display gating disables; reset value trimmed by the variant mask too
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      display_gating_disable <= PTC_RST_DISP & disp_wmask;
    else if (wr_en && wr_addr == PTC_OFF_DISP)
      display_gating_disable <= ptc_merge(display_gating_disable, wr_data, wr_strb, disp_wmask);
  end

  // render gating disables are only stored and passed on
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      render_gating_disable_one <= PTC_RST_REND;
    else if (wr_en && wr_addr == PTC_OFF_REND)
      render_gating_disable_one <= ptc_merge(render_gating_disable_one, wr_data, wr_strb,
                                             32'hFFFFFFFF);
  end

  // read mux; status shows what the d3 logic is doing right now
  always_comb
  begin
    case (rd_addr)
      PTC_OFF_TEST: rd_data = pll_test_control;
      PTC_OFF_PSTATE: rd_data = power_state_clock_control;
      PTC_OFF_STATUS: rd_data = {28'h0000000, status_bits};
      PTC_OFF_DISP: rd_data = display_gating_disable;
      PTC_OFF_REND: rd_data = render_gating_disable_one;
      default: rd_data = 32'h00000000;
    endcase
  end

  // ****************************************
  // pll test pins
  // ****************************************
  // pins are {second pll, first pll}
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      input_divider_bypass_pin <= 2'h0;
      feedback_divider_bypass_pin <= 2'h0;
      feedback_source_select_pin <= 2'h0;
      input_buffer_enable_pin <= 2'h3;
    end
    else
    begin
      input_divider_bypass_pin <= {pll_test_control[PTC_B_NDIV_B],
                                   pll_test_control[PTC_B_NDIV_A]};
      feedback_divider_bypass_pin <= {pll_test_control[PTC_B_MDIV_B],
                                      pll_test_control[PTC_B_MDIV_A]};
      feedback_source_select_pin <= {pll_test_control[PTC_B_FBSEL_B],
                                     pll_test_control[PTC_B_FBSEL_A]};
      input_buffer_enable_pin <= {pll_test_control[PTC_B_BUF_B],
                                  pll_test_control[PTC_B_BUF_A]};
    end
  end

  // post-divider select is held at zero (output grounded) without core feedback
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      feedback_postdiv_select_pins <= 2'h0;
    else if (pll_test_control[PTC_B_FBSEL_A])
      feedback_postdiv_select_pins <= pll_test_control[PTC_B_POSTDIV +: 2];
    else
      feedback_postdiv_select_pins <= 2'h0;
  end

  // ****************************************
  // d3 power actions
  // ****************************************
  logic in_d3;
  logic core_clk_gate_en;
  logic dot_clk_gate_en;

  assign in_d3 = (host_power_state == PTC_PM_D3);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dot_pll_power_down <= 1'b0;
      core_clk_gate_en <= 1'b1;
      dot_clk_gate_en <= 1'b1;
    end
    else
    begin
      dot_pll_power_down <= in_d3 && power_state_clock_control[PTC_B_PD_D3];
      core_clk_gate_en <= !(in_d3 && power_state_clock_control[PTC_B_CORE_D3]);
      dot_clk_gate_en <= !(in_d3 && power_state_clock_control[PTC_B_DOT_D3]);
    end
  end

  assign status_bits = {!dot_clk_gate_en, !core_clk_gate_en, dot_pll_power_down, in_d3};

  // gating cells retime the enable, so a setting change never clips a pulse
  for (genvar i = 0; i < 2; i++)
  begin : g_dot_gate
    ptc_clk_gate u_dot
    (
      .clk_in(dot_clk_in[i]),
      .gate_en(dot_clk_gate_en),
      .clk_out(dot_clk_out[i])
    );
  end

  ptc_clk_gate u_core
  (
    .clk_in(core_clk_in),
    .gate_en(core_clk_gate_en),
    .clk_out(core_clk_out)
  );

  // ****************************************
  // display unit clock enables
  // ****************************************
  // bits 30/25 feed the pipe planes and 8/7 the pipe gamma units, each on its own
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      disp_clk_run <= 31'h00000000;
      render_gating_disable <= 32'h00000000;
    end
    else
    begin
      disp_clk_run <= disp_unit_enable | display_gating_disable[30:0];
      render_gating_disable <= render_gating_disable_one;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_test_write;
    wr_en && wr_addr == PTC_OFF_TEST && wr_strb == 4'hF;
  endsequence

  a_ndiv_pin: assert property (s_test_write ##2 1 |->
    input_divider_bypass_pin == {$past(wr_data[PTC_B_NDIV_B], 2), $past(wr_data[PTC_B_NDIV_A], 2)})
    else $error("input divider bypass pin does not follow register");
  a_mdiv_pin: assert property (##1 feedback_divider_bypass_pin ==
    {$past(pll_test_control[PTC_B_MDIV_B]), $past(pll_test_control[PTC_B_MDIV_A])})
    else $error("feedback divider bypass pin wrong");
  a_fbsel_pin: assert property (s_test_write |-> ##2
    feedback_source_select_pin[0] == $past(wr_data[PTC_B_FBSEL_A], 2))
    else $error("feedback select pin wrong");
  a_buf_pin: assert property ($past(sys_rst) |->
    pll_test_control == PTC_RST_TEST ##1 input_buffer_enable_pin == 2'h3)
    else $error("input buffers not enabled after reset");
  a_postdiv_gnd: assert property (!pll_test_control[PTC_B_FBSEL_A] |=>
    feedback_postdiv_select_pins == 2'h0)
    else $error("post-divider select active without core feedback");
  a_pll_pd: assert property (power_state_clock_control[PTC_B_PD_D3] && in_d3 |=>
    dot_pll_power_down && status_bits[1])
    else $error("dot plls not powered down in d3");
  a_core_gate: assert property (power_state_clock_control[PTC_B_CORE_D3] && in_d3 |=>
    !core_clk_gate_en)
    else $error("core clocks not gated in d3");
  a_dot_gate: assert property (power_state_clock_control[PTC_B_DOT_D3] && in_d3 |=>
    !dot_clk_gate_en)
    else $error("dot clocks not gated in d3");
  a_no_d3_act: assert property (!in_d3 |=>
    !dot_pll_power_down && core_clk_gate_en && dot_clk_gate_en)
    else $error("d3 action taken outside d3");
  a_disp_run: assert property (!sys_rst |=>
    (disp_clk_run & $past(display_gating_disable[30:0])) == $past(display_gating_disable[30:0]))
    else $error("disabled unit clock not forced to run");
  a_nc_bits: assert property (VARIANT_NC |->
    (display_gating_disable & PTC_MASK_DISP_NC) == 32'h00000000)
    else $error("unconnected display gating bit stored");
  a_plane_pipe: assert property (!disp_unit_enable[PTC_B_PLANE_A] &&
    display_gating_disable[PTC_B_PLANE_B] && !display_gating_disable[PTC_B_PLANE_A] |=>
    disp_clk_run[PTC_B_PLANE_B] && !disp_clk_run[PTC_B_PLANE_A])
    else $error("plane unit disables not separate per pipe");

endmodule

// *** verif/tb_ptc_top.sv ***
// self-checking testbench for the pll test and clock gating block
`timescale 1ns/1ns
module tb_ptc_top
  import ptc_pkg::*;
();
  // ****************************************
  // signals and stimulus tables
  // ****************************************
  logic ref_clk;
  logic sys_rst;
  logic [15:0] s_axil_awaddr;
  logic s_axil_awvalid;
  logic s_axil_awready;
  logic [31:0] s_axil_wdata;
  logic [3:0] s_axil_wstrb;
  logic s_axil_wvalid;
  logic s_axil_wready;
  logic [1:0] s_axil_bresp;
  logic s_axil_bvalid;
  logic s_axil_bready;
  logic [15:0] s_axil_araddr;
  logic s_axil_arvalid;
  logic s_axil_arready;
  logic [31:0] s_axil_rdata;
  logic [1:0] s_axil_rresp;
  logic s_axil_rvalid;
  logic s_axil_rready;
  logic [1:0] host_power_state;
  logic [30:0] disp_unit_enable;
  logic [1:0] ndiv_pin, mdiv_pin, fbsel_pin, buf_pin, postdiv_pin;
  logic dot_pll_power_down;
  logic [30:0] disp_clk_run;
  logic [30:0] nc_run;
  logic [31:0] render_gating_disable;
  logic [1:0] dot_clk_out;
  logic core_clk_out;
  logic [9:0] pins;
  int err_total;
  int comparisons;
  logic [15:0] radr [4] = '{16'h606C, 16'h6104, 16'h6200, 16'h6204};
  logic [31:0] rrst [4] = '{32'h00010001, 32'h0, 32'h01000000, 32'h0};
  logic [31:0] tv [4] = '{32'hFFFFFFFF, 32'h00000030, 32'h000A0005, 32'h00050012};
  logic [31:0] pv [6] = '{32'hB, 32'h1, 32'h2, 32'h8, 32'h0, 32'hB};
  // bit 28 kept set in every display write, as software must
  // second write sets only pipe b plane and gamma bits, third only pipe a
  logic [31:0] dv [3] = '{32'hFFFFFFFF, 32'h50000100, 32'h12000080};
  logic [30:0] ev [3] = '{31'h0, 31'h0, 31'h15555555};

  assign pins = {ndiv_pin, mdiv_pin, fbsel_pin, buf_pin, postdiv_pin};

  // gated clocks are fed from the bench clock so their level is known at mid-high phase
  ptc_top dut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .host_power_state(host_power_state), .disp_unit_enable(disp_unit_enable),
    .dot_clk_in({ref_clk, ref_clk}), .core_clk_in(ref_clk),
    .input_divider_bypass_pin(ndiv_pin), .feedback_divider_bypass_pin(mdiv_pin),
    .feedback_source_select_pin(fbsel_pin), .input_buffer_enable_pin(buf_pin),
    .feedback_postdiv_select_pins(postdiv_pin), .dot_pll_power_down(dot_pll_power_down),
    .disp_clk_run(disp_clk_run), .render_gating_disable(render_gating_disable),
    .dot_clk_out(dot_clk_out), .core_clk_out(core_clk_out)
  );

  // trimmed variant on the same inputs; its bus answers mirror dut, so only unit runs are watched
  ptc_top #(.VARIANT_NC(1'b1)) dut_nc
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(),
    .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(), .s_axil_bresp(), .s_axil_bvalid(), .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(),
    .s_axil_rdata(), .s_axil_rresp(), .s_axil_rvalid(), .s_axil_rready(s_axil_rready),
    .host_power_state(host_power_state), .disp_unit_enable(disp_unit_enable),
    .dot_clk_in({ref_clk, ref_clk}), .core_clk_in(ref_clk),
    .input_divider_bypass_pin(), .feedback_divider_bypass_pin(),
    .feedback_source_select_pin(), .input_buffer_enable_pin(),
    .feedback_postdiv_select_pins(), .dot_pll_power_down(),
    .disp_clk_run(nc_run), .render_gating_disable(), .dot_clk_out(), .core_clk_out()
  );

  // 100 MHz bench clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  // pin image expected from a test register value; post-divider only with core feedback
  function automatic logic [9:0] pin_exp(input logic [31:0] t);
    return {t[19], t[3], t[18], t[2], t[17], t[1], t[16], t[0], t[1] ? t[5:4] : 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("ERROR t=%0t no answer to %s", $time, what);
    final_report();
  endtask

  // address and data offered together; each released at its own handshake edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wstrb <= s;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    for (n = 0; n < 50 && !done; n++)
    begin
      @(posedge ref_clk);
      if (s_axil_awready === 1'b1)
        s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1)
        s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid === 1'b1)
      begin
        done = 1'b1;
        s_axil_bready <= 1'b0;
        chk(s_axil_bresp, er, "bresp");
      end
    end
    if (!done)
      hang("write");
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++)
    begin
      @(posedge ref_clk);
      if (s_axil_arready === 1'b1)
        s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid === 1'b1)
      begin
        done = 1'b1;
        s_axil_rready <= 1'b0;
        chk(s_axil_rdata, e, "rdata");
        chk(s_axil_rresp, er, "rresp");
      end
    end
    if (!done)
      hang("read");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int i;
    logic d3, pd, cg, dg;
    err_total = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    s_axil_awaddr = 16'h0;
    s_axil_awvalid = 1'b0;
    s_axil_wdata = 32'h0;
    s_axil_wstrb = 4'h0;
    s_axil_wvalid = 1'b0;
    s_axil_bready = 1'b0;
    s_axil_araddr = 16'h0;
    s_axil_arvalid = 1'b0;
    s_axil_rready = 1'b0;
    host_power_state = 2'h0;
    disp_unit_enable = 31'h0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // register reset values and pin state straight after reset
    for (i = 0; i < 4; i++)
      rd_chk(radr[i], rrst[i], PTC_RESP_OKAY);
    chk(pins, pin_exp(32'h00010001), "reset pins");
    // pll test bits onto the pins, including post-divider with feedback select low
    for (i = 0; i < 4; i++)
    begin
      wr(PTC_OFF_TEST, tv[i], 4'hF, PTC_RESP_OKAY);
      rd_chk(PTC_OFF_TEST, tv[i] & PTC_MASK_TEST, PTC_RESP_OKAY);
      chk(pins, pin_exp(tv[i]), "test pins");
    end
    // automatic d3 actions for each control bit, last pass out of d3
    for (i = 0; i < 6; i++)
    begin
      host_power_state <= (i == 5) ? 2'h2 : 2'h3;
      wr(PTC_OFF_PSTATE, pv[i] | 32'h4, 4'hF, PTC_RESP_OKAY);
      rd_chk(PTC_OFF_PSTATE, pv[i], PTC_RESP_OKAY);
      d3 = (i != 5);
      pd = pv[i][3] & d3;
      cg = pv[i][1] & d3;
      dg = pv[i][0] & d3;
      repeat (6) @(posedge ref_clk);
      #1;
      chk({core_clk_out, dot_clk_out, dot_pll_power_down}, {~cg, ~dg, ~dg, pd}, "d3");
      rd_chk(PTC_OFF_STATUS, {28'h0, dg, cg, pd, d3}, PTC_RESP_OKAY);
    end
    // display disables force units on, per-pipe plane and gamma bits included
    for (i = 0; i < 3; i++)
    begin
      disp_unit_enable <= ev[i];
      wr(PTC_OFF_DISP, dv[i], 4'hF, PTC_RESP_OKAY);
      rd_chk(PTC_OFF_DISP, dv[i] & PTC_MASK_DISP, PTC_RESP_OKAY);
      chk(disp_clk_run, ev[i] | dv[i][30:0], "unit run");
      chk(nc_run, ev[i] | (dv[i][30:0] & ~PTC_MASK_DISP_NC[30:0]), "variant run");
    end
    // render register with partial strobes, then an unmapped address
    wr(PTC_OFF_REND, 32'hFFFFFFFF, 4'hF, PTC_RESP_OKAY);
    wr(PTC_OFF_REND, 32'h0, 4'h5, PTC_RESP_OKAY);
    rd_chk(PTC_OFF_REND, 32'hFF00FF00, PTC_RESP_OKAY);
    chk(render_gating_disable, 32'hFF00FF00, "render copy");
    wr(16'h6300, 32'h12345678, 4'hF, PTC_RESP_SLVERR);
    rd_chk(16'h6300, 32'h0, PTC_RESP_SLVERR);
    // a second reset in mid-run restores the buffers-on default
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(PTC_OFF_TEST, 32'h00010001, PTC_RESP_OKAY);
    chk(pins, pin_exp(32'h00010001), "pins after reset");
    final_report();
  end
endmodule
